/* File: core/strap_defines.svh */
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define STRAP_ADDR_W          8
`define STRAP_OFF_CTRL        8'h00
`define STRAP_OFF_STRAPS      8'h04
`define STRAP_OFF_LED_DIRECT  8'h08
`define STRAP_OFF_LED_SERIAL  8'h0C
`define STRAP_OFF_STATUS      8'h10

// ==========================================================================
// Field positions
`define STRAP_CTRL_FWD_BIT    0
`define STRAP_ST_DONE_BIT     0
`define STRAP_ST_PEND_BIT     1
`define STRAP_LED_PINS        10
`define STRAP_SER_W           16

// ==========================================================================
// Pull defaults of the pads, used until the straps are captured
`define STRAP_PULL_SELFTEST   1'b1
`define STRAP_PULL_VOLTAGE    1'b0
`define STRAP_PULL_FREQ1      1'b1
`define STRAP_PULL_WAN        1'b0
`define STRAP_PULL_REFSEL     1'b0
`define STRAP_PULL_MGMT       1'b0
`define STRAP_PULL_IFACE      1'b1
`define STRAP_PULL_FWD        1'b1
`define STRAP_PULL_MODE1      1'b0
`define STRAP_PULL_MODE0      1'b0
`define STRAP_PULL_FREQ0      1'b0

// ==========================================================================
// Core frequency codes, in MHz
`define STRAP_MHZ_00          8'h7D
`define STRAP_MHZ_01          8'h8E
`define STRAP_MHZ_10          8'hC8
`define STRAP_MHZ_11          8'hA7

// ==========================================================================
// Timing counts
`define STRAP_SETTLE_CYCLES   2'h3
`define STRAP_LED_GAP_CYCLES  8'hC8
`define STRAP_LAST_BIT        5'h0F

`endif

/* File: core/strap_pkg.sv */
`include "strap_defines.svh"

package strap_pkg;

    typedef enum logic [0:0] {
        STRAP_CAPTURE,
        STRAP_RUN
    } strap_phase_t;

    typedef enum logic [1:0] {
        STRAP_L_IDLE,
        STRAP_L_LOW,
        STRAP_L_HIGH
    } strap_lphase_t;

    typedef struct packed {
        logic [11:0]                     pin_meta;
        logic [11:0]                     pin_sync;
        strap_phase_t                    phase;
        logic [1:0]                      settle;
        logic                            selftest;
        logic                            voltage;
        logic [1:0]                      freq;
        logic                            wan;
        logic                            refsel;
        logic                            mgmt;
        logic                            iface;
        logic                            fwd;
        logic [1:0]                      mode;
        logic                            sw_fwd;
        logic [`STRAP_LED_PINS-1:0]      led_direct;
        logic [`STRAP_SER_W-1:0]         led_serial;
        logic [`STRAP_SER_W-1:0]         shadow;
        logic                            req_tgl;
        logic                            ack_meta;
        logic                            ack_sync;
        logic [31:0]                     rdata;
        logic                            fwd_out;
        logic [7:0]                      freq_mhz;
        logic                            ref_50;
        logic [`STRAP_LED_PINS-1:0]      pin_out;
        logic [`STRAP_LED_PINS-1:0]      pin_oe;
    } strap_core_t;

    typedef struct packed {
        logic [1:0]                      rst_sync;
        logic                            req_meta;
        logic                            req_sync;
        logic                            req_prev;
        logic                            ack_tgl;
        logic                            done_meta;
        logic                            done_sync;
        logic [`STRAP_SER_W-1:0]         word;
        logic [`STRAP_SER_W-1:0]         sreg;
        logic [7:0]                      gap;
        logic [4:0]                      bit_cnt;
        strap_lphase_t                   lphase;
        logic                            clk_out;
        logic                            data_out;
        logic                            oe;
    } strap_link_t;

endpackage : strap_pkg

/* File: core/strap_led.sv */
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "strap_defines.svh"

// How it works
// RULE1 - Self-test runs when strap reads one
// RULE2 - Voltage strap zero 2.5V, one 1.5V
// RULE3 - WAN port RGMII only when strap low
// RULE4 - Management port RGMII only when strap low
// RULE5 - Later revision: fifth LED picks 50/25 MHz
// RULE6 - Interface strap: zero EEPROM, one serial host
// RULE7 - Pseudo-PHY host needs serial host selected
// RULE8 - Forwarding strap high forwards with defaults
// RULE9 - Forwarding strap low waits for software bit
// RULE10 - LED shift clock runs only in bursts
// RULE11 - LED data shifts only during clock bursts
// RULE12 - Two-bit LED mode, bit zero from clock
// RULE13 - Core frequency code maps to four rates
// RULE14 - Frequency bit one from third LED pin
// RULE15 - Interface strap steers shared serial data pins
// RULE16 - Straps sampled once at reset release, held
// RULE17 - Unfitted strap reads pad pull default
module strap_led
    import strap_pkg::*;
#(
    parameter logic REV_B = 1'b1
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_nrst,
    input  wire logic                         i_led_link_clock,
    input  wire logic [`STRAP_ADDR_W-1:0]     i_addr,
    input  wire logic [31:0]                  i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [31:0]                  o_rdata,
    input  wire logic [`STRAP_LED_PINS-1:0]   i_led_pin_in,
    output logic      [`STRAP_LED_PINS-1:0]   o_led_pin_out,
    output logic      [`STRAP_LED_PINS-1:0]   o_led_pin_oe,
    input  wire logic                         i_led_shift_clock_in,
    output logic                              o_led_shift_clock,
    output logic                              o_led_shift_clock_oe,
    input  wire logic                         i_led_serial_data_in,
    output logic                              o_led_serial_data,
    output logic                              o_led_serial_data_oe,
    output logic                              o_config_done,
    output logic                              o_run_selftest,
    output logic                              o_mgmt_voltage_1v5,
    output logic                              o_wan_port_rgmii,
    output logic                              o_mgmt_port_rgmii,
    output logic                              o_ref_clock_50mhz,
    output logic                              o_serial_host_iface,
    output logic                              o_default_forwarding_enable,
    output logic      [1:0]                   o_core_freq_select,
    output logic      [7:0]                   o_core_freq_mhz,
    output logic      [1:0]                   o_led_display_mode
);

    // ======================================================================
    // Helpers
    function automatic logic [7:0] freq_mhz_of(input logic [1:0] code);
        logic [7:0] mhz;
        mhz = `STRAP_MHZ_00;
        unique case (code)
            2'h0: mhz = `STRAP_MHZ_00;
            2'h1: mhz = `STRAP_MHZ_01;
            2'h2: mhz = `STRAP_MHZ_10;
            2'h3: mhz = `STRAP_MHZ_11;
        endcase
        return mhz;
    endfunction : freq_mhz_of

    function automatic logic [31:0] pad32(input logic [15:0] v);
        return {16'h0000, v};
    endfunction : pad32

    // ======================================================================
    // Reset images
    // RULE17 pull defaults
    localparam strap_core_t CORE_RST = '{
        pin_meta:   12'h000,
        pin_sync:   12'h000,
        phase:      STRAP_CAPTURE,
        settle:     2'h0,
        selftest:   `STRAP_PULL_SELFTEST,
        voltage:    `STRAP_PULL_VOLTAGE,
        freq:       {`STRAP_PULL_FREQ1, `STRAP_PULL_FREQ0},
        wan:        ~`STRAP_PULL_WAN,
        refsel:     `STRAP_PULL_REFSEL,
        mgmt:       ~`STRAP_PULL_MGMT,
        iface:      `STRAP_PULL_IFACE,
        fwd:        `STRAP_PULL_FWD,
        mode:       {`STRAP_PULL_MODE1, `STRAP_PULL_MODE0},
        sw_fwd:     1'b0,
        led_direct: 10'h000,
        led_serial: 16'h0000,
        shadow:     16'h0000,
        req_tgl:    1'b0,
        ack_meta:   1'b0,
        ack_sync:   1'b0,
        rdata:      32'h0000_0000,
        fwd_out:    1'b0,
        freq_mhz:   8'h00,
        ref_50:     1'b0,
        pin_out:    10'h000,
        pin_oe:     10'h000
    };

    strap_core_t core_reg;
    strap_core_t core_next;
    strap_link_t link_reg;
    strap_link_t link_next;

    // ======================================================================
    // Core domain: strap capture, control outputs, register port
    always_comb begin
        logic [11:0] s;
        logic        pend;
        s         = core_reg.pin_sync;
        pend      = core_reg.req_tgl != core_reg.ack_sync;
        core_next = core_reg;

        // Pads pass two flops before anything looks at them
        core_next.pin_meta = {i_led_serial_data_in, i_led_shift_clock_in,
                              i_led_pin_in};
        core_next.pin_sync = core_reg.pin_meta;
        core_next.ack_meta = link_reg.ack_tgl;
        core_next.ack_sync = core_reg.ack_meta;

        unique case (core_reg.phase)
            STRAP_CAPTURE: begin
                // Pads stay undriven so board resistors or pulls set levels
                core_next.pin_oe = '0;
                if (core_reg.settle != `STRAP_SETTLE_CYCLES) begin
                    core_next.settle = core_reg.settle + 2'h1;
                end else begin
                    // RULE16 one-shot capture
                    core_next.phase    = STRAP_RUN;
                    // Pads turn to LED duty on the same edge as done
                    core_next.pin_oe   = {`STRAP_LED_PINS{1'b1}};
                    core_next.selftest = s[1];
                    core_next.voltage  = s[2];
                    // RULE14 bit one pin
                    core_next.freq     = {s[3], s[11]};
                    // Mode bits kept as RGMII flags so outputs need no gate
                    core_next.wan      = ~s[4];
                    core_next.refsel   = s[5];
                    core_next.mgmt     = ~s[6];
                    core_next.iface    = s[8];
                    core_next.fwd      = s[9];
                    // RULE12 mode from clock pin
                    core_next.mode     = {s[7], s[10]};
                end
            end
            STRAP_RUN: begin
                // Captured straps are never touched again here
                core_next.pin_oe = {`STRAP_LED_PINS{1'b1}};
            end
        endcase

        core_next.pin_out = core_reg.led_direct;

        // RULE5 revision dependent
        core_next.ref_50 = REV_B & core_reg.refsel;

        // RULE13 frequency decode
        core_next.freq_mhz = freq_mhz_of(core_reg.freq);

        // RULE8 strap forwards
        // RULE9 software enable
        core_next.fwd_out = core_reg.fwd | core_reg.sw_fwd;

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                `STRAP_OFF_CTRL:
                    core_next.sw_fwd = i_wdata[`STRAP_CTRL_FWD_BIT];
                `STRAP_OFF_LED_DIRECT:
                    core_next.led_direct = i_wdata[`STRAP_LED_PINS-1:0];
                `STRAP_OFF_LED_SERIAL:
                    core_next.led_serial = i_wdata[`STRAP_SER_W-1:0];
                default: begin
                end
            endcase
        end

        // Register reads: data valid only in the cycle after the strobe
        core_next.rdata = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                `STRAP_OFF_CTRL:
                    core_next.rdata = {31'h0, core_reg.sw_fwd};
                `STRAP_OFF_STRAPS:
                    core_next.rdata = pad32({4'h0, core_reg.mode,
                        core_reg.fwd, core_reg.iface, ~core_reg.mgmt,
                        core_reg.refsel, ~core_reg.wan, core_reg.freq,
                        core_reg.voltage, core_reg.selftest, 1'b0});
                `STRAP_OFF_LED_DIRECT:
                    core_next.rdata = {22'h0, core_reg.led_direct};
                `STRAP_OFF_LED_SERIAL:
                    core_next.rdata = pad32(core_reg.led_serial);
                `STRAP_OFF_STATUS:
                    core_next.rdata = {30'h0, pend,
                                       core_reg.phase == STRAP_RUN};
                default:
                    core_next.rdata = 32'h0000_0000;
            endcase
        end

        // Hand the serial word over; shadow is frozen while a handshake
        // is open, so the link side may copy it without a race
        if (!pend && core_reg.shadow != core_reg.led_serial) begin
            core_next.shadow  = core_reg.led_serial;
            core_next.req_tgl = ~core_reg.req_tgl;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            core_reg <= CORE_RST;
        end else begin
            core_reg <= core_next;
        end
    end

    // ======================================================================
    // Link domain: periodic LED shift bursts
    always_comb begin
        link_next          = link_reg;
        link_next.rst_sync = {link_reg.rst_sync[0], 1'b1};
        link_next.req_meta = core_reg.req_tgl;
        link_next.req_sync = link_reg.req_meta;
        link_next.done_meta = core_reg.phase == STRAP_RUN;
        link_next.done_sync = link_reg.done_meta;

        if (link_reg.req_sync != link_reg.req_prev) begin
            link_next.word     = core_reg.shadow;
            link_next.req_prev = link_reg.req_sync;
            link_next.ack_tgl  = ~link_reg.ack_tgl;
        end

        // Pins held undriven until straps are captured
        link_next.oe = link_reg.done_sync;

        unique case (link_reg.lphase)
            STRAP_L_IDLE: begin
                // RULE10 clock quiet between bursts
                link_next.clk_out  = 1'b0;
                // RULE11 data quiet between bursts
                link_next.data_out = 1'b0;
                if (link_reg.done_sync) begin
                    if (link_reg.gap == `STRAP_LED_GAP_CYCLES) begin
                        link_next.gap      = 8'h00;
                        link_next.sreg     = link_reg.word;
                        link_next.bit_cnt  = 5'h00;
                        link_next.lphase   = STRAP_L_LOW;
                        link_next.data_out = link_reg.word[`STRAP_SER_W-1];
                    end else begin
                        link_next.gap = link_reg.gap + 8'h01;
                    end
                end
            end
            STRAP_L_LOW: begin
                // RULE10 burst clock edge
                link_next.clk_out = 1'b1;
                link_next.lphase  = STRAP_L_HIGH;
            end
            STRAP_L_HIGH: begin
                link_next.clk_out = 1'b0;
                if (link_reg.bit_cnt == `STRAP_LAST_BIT) begin
                    link_next.lphase   = STRAP_L_IDLE;
                    link_next.data_out = 1'b0;
                end else begin
                    // RULE11 shift next bit
                    link_next.sreg    = {link_reg.sreg[`STRAP_SER_W-2:0],
                                         1'b0};
                    link_next.bit_cnt = link_reg.bit_cnt + 5'h01;
                    link_next.lphase  = STRAP_L_LOW;
                    link_next.data_out = link_reg.sreg[`STRAP_SER_W-2];
                end
            end
            default: begin
                link_next.lphase = STRAP_L_IDLE;
            end
        endcase

        // Hold everything but the reset shifter until reset has settled
        if (!link_reg.rst_sync[1]) begin
            link_next          = '0;
            link_next.rst_sync = {link_reg.rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge i_led_link_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // ======================================================================
    // Outputs, each straight from a flop
    assign o_rdata              = core_reg.rdata;
    assign o_led_pin_out        = core_reg.pin_out;
    assign o_led_pin_oe         = core_reg.pin_oe;
    assign o_led_shift_clock    = link_reg.clk_out;
    assign o_led_shift_clock_oe = link_reg.oe;
    assign o_led_serial_data    = link_reg.data_out;
    assign o_led_serial_data_oe = link_reg.oe;
    assign o_config_done        = core_reg.phase == STRAP_RUN;

    // RULE1 self-test select
    assign o_run_selftest       = core_reg.selftest;
    // RULE2 voltage select
    assign o_mgmt_voltage_1v5   = core_reg.voltage;
    // RULE3 WAN mode, one reserved
    assign o_wan_port_rgmii     = core_reg.wan;
    // RULE4 management mode, one reserved
    assign o_mgmt_port_rgmii    = core_reg.mgmt;
    assign o_ref_clock_50mhz    = core_reg.ref_50;
    // RULE6 interface choice
    // RULE15 shared pin steering
    // RULE7 host must see one here
    assign o_serial_host_iface  = core_reg.iface;
    assign o_default_forwarding_enable = core_reg.fwd_out;
    assign o_core_freq_select   = core_reg.freq;
    assign o_core_freq_mhz      = core_reg.freq_mhz;
    assign o_led_display_mode   = core_reg.mode;

endmodule : strap_led

/* File: verif/strap_led_asserts.sv */
`timescale 1ns/10ps
`include "strap_defines.svh"

module strap_led_asserts
    import strap_pkg::*;
(
    input  wire logic                       i_clock,
    input  wire logic                       i_nrst,
    input  wire logic                       i_led_link_clock,
    input  wire logic [`STRAP_ADDR_W-1:0]   i_addr,
    input  wire logic [31:0]                i_wdata,
    input  wire logic                       i_wr,
    input  wire logic [`STRAP_LED_PINS-1:0] o_led_pin_oe,
    input  wire logic                       o_led_shift_clock,
    input  wire logic                       o_led_shift_clock_oe,
    input  wire logic                       o_led_serial_data,
    input  wire logic                       o_config_done,
    input  wire logic                       o_run_selftest,
    input  wire logic                       o_mgmt_voltage_1v5,
    input  wire logic                       o_serial_host_iface,
    input  wire logic                       o_default_forwarding_enable,
    input  wire logic [1:0]                 o_core_freq_select,
    input  wire logic [1:0]                 o_led_display_mode
);

    // ========================================================
    // Core domain
    // capture is final
    a_done_sticky: assert property (
        @(posedge i_clock) disable iff (!i_nrst) o_config_done |=> o_config_done)
        else $error("config done dropped");
    a_pin_oe_done: assert property (
        @(posedge i_clock) disable iff (!i_nrst)
        o_led_pin_oe == {`STRAP_LED_PINS{o_config_done}})
        else $error("pin enables disagree with config done");
    a_strap_hold: assert property (
        @(posedge i_clock) disable iff (!i_nrst) $past(o_config_done, 2) |->
        $stable({o_run_selftest, o_mgmt_voltage_1v5, o_serial_host_iface,
                 o_core_freq_select, o_led_display_mode}))
        else $error("strap output changed after capture");
    a_fwd_write: assert property (
        @(posedge i_clock) disable iff (!i_nrst)
        i_wr && i_addr == `STRAP_OFF_CTRL && i_wdata[0] |->
        ##2 o_default_forwarding_enable)
        else $error("forwarding not enabled by control write");

    // ========================================================
    // Link domain
    // Two idle cycles after a pulse mark the end of a burst
    sequence s_burst_end;
        $fell(o_led_shift_clock) ##1 !o_led_shift_clock;
    endsequence

    a_clk_needs_oe: assert property (
        @(posedge i_led_link_clock) disable iff (!i_nrst)
        o_led_shift_clock |-> o_led_shift_clock_oe)
        else $error("shift clock high while not driven");
    a_clk_one_high: assert property (
        @(posedge i_led_link_clock) disable iff (!i_nrst)
        o_led_shift_clock |=> !o_led_shift_clock)
        else $error("shift clock high for two cycles");
    a_data_setup: assert property (
        @(posedge i_led_link_clock) disable iff (!i_nrst)
        $rose(o_led_shift_clock) |-> $stable(o_led_serial_data))
        else $error("serial data moved with clock rise");
    a_burst_gap: assert property (
        @(posedge i_led_link_clock) disable iff (!i_nrst)
        s_burst_end |=> !o_led_shift_clock [*8])
        else $error("shift clock restarted without gap");

endmodule : strap_led_asserts

bind strap_led strap_led_asserts u_asserts (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_led_link_clock(i_led_link_clock),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .o_led_pin_oe(o_led_pin_oe), .o_led_shift_clock(o_led_shift_clock),
    .o_led_shift_clock_oe(o_led_shift_clock_oe),
    .o_led_serial_data(o_led_serial_data), .o_config_done(o_config_done),
    .o_run_selftest(o_run_selftest), .o_mgmt_voltage_1v5(o_mgmt_voltage_1v5),
    .o_serial_host_iface(o_serial_host_iface),
    .o_default_forwarding_enable(o_default_forwarding_enable),
    .o_core_freq_select(o_core_freq_select),
    .o_led_display_mode(o_led_display_mode)
);

/* File: verif/strap_board_model.sv */
`timescale 1ns/10ps

module strap_board_model
    import strap_pkg::*;
(
    input  wire logic        i_nrst,
    input  wire logic [9:0]  i_pin_out,
    input  wire logic [9:0]  i_pin_oe,
    input  wire logic        i_clk_out,
    input  wire logic        i_clk_oe,
    input  wire logic        i_data_out,
    input  wire logic        i_data_oe,
    input  wire logic [11:0] i_strap,
    input  wire logic [11:0] i_fitted,
    output logic      [9:0]  o_pin_in,
    output logic             o_clk_in,
    output logic             o_data_in,
    output logic      [15:0] o_word
);
    logic [11:0] level;
    logic [15:0] sr;
    int          nbits;

    // pulls apply, WAN and management mode straps held low
    assign level = ((i_fitted & i_strap) | (~i_fitted & 12'h30A)) & 12'hFAF;
    // Released pads fall back to the strap level, never the last value
    assign o_pin_in  = (i_pin_oe & i_pin_out) | (~i_pin_oe & level[9:0]);
    assign o_clk_in  = i_clk_oe ? i_clk_out : level[10];
    assign o_data_in = i_data_oe ? i_data_out : level[11];

    always @(posedge i_clk_out or negedge i_nrst) begin
        if (!i_nrst) begin
            nbits = 0;
        end else if (i_clk_oe) begin
            sr    = {sr[14:0], i_data_out};
            nbits = nbits + 1;
            if (nbits == 16) begin
                o_word = sr;
                nbits  = 0;
            end
        end
    end
endmodule : strap_board_model

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`include "strap_defines.svh"

module tb_top import strap_pkg::*;;
    logic        i_clock, i_nrst, i_led_link_clock, i_wr, i_rd;
    logic [7:0]  i_addr, o_core_freq_mhz;
    logic [31:0] i_wdata, o_rdata, d, x;
    logic [9:0]  i_led_pin_in, o_led_pin_out, o_led_pin_oe;
    logic        i_led_shift_clock_in, o_led_shift_clock, o_led_shift_clock_oe;
    logic        i_led_serial_data_in, o_led_serial_data, o_led_serial_data_oe;
    logic        o_config_done, o_run_selftest, o_mgmt_voltage_1v5;
    logic        o_wan_port_rgmii, o_mgmt_port_rgmii, o_ref_clock_50mhz;
    logic        o_serial_host_iface, o_default_forwarding_enable;
    logic [1:0]  o_core_freq_select, o_led_display_mode;
    logic [11:0] strap, fitted, eff;
    logic [15:0] word, seen_word;
    // serial host kept selected in most patterns
    logic [11:0] pats [5] = '{12'h000, 12'h8A0, 12'h70F, 12'hFAF, 12'h000};
    logic [7:0]  mhz [4] = '{8'h7D, 8'h8E, 8'hC8, 8'hA7};
    int          errors, n_compared, n;

    strap_led #(.REV_B(1'b1)) DUT (.*);

    strap_board_model u_board (
        .i_nrst(i_nrst), .i_pin_out(o_led_pin_out), .i_pin_oe(o_led_pin_oe),
        .i_clk_out(o_led_shift_clock), .i_clk_oe(o_led_shift_clock_oe),
        .i_data_out(o_led_serial_data), .i_data_oe(o_led_serial_data_oe),
        .i_strap(strap), .i_fitted(fitted), .o_pin_in(i_led_pin_in),
        .o_clk_in(i_led_shift_clock_in), .o_data_in(i_led_serial_data_in),
        .o_word(seen_word)
    );

    always #5 i_clock = ~i_clock;
    always #80 i_led_link_clock = ~i_led_link_clock;

    // ========================================================
    // Access and check tasks
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1 v = o_rdata;
    endtask : rd

    task automatic summarize();
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic check_straps(input logic sw);
        chk("selftest", {31'h0, o_run_selftest}, {31'h0, eff[1]});
        chk("volt", {31'h0, o_mgmt_voltage_1v5}, {31'h0, eff[2]});
        chk("wan", {31'h0, o_wan_port_rgmii}, {31'h0, !eff[4]});
        chk("mgmt", {31'h0, o_mgmt_port_rgmii}, {31'h0, !eff[6]});
        chk("ref", {31'h0, o_ref_clock_50mhz}, {31'h0, eff[5]});
        chk("iface", {31'h0, o_serial_host_iface}, {31'h0, eff[8]});
        chk("fwd", {31'h0, o_default_forwarding_enable},
            {31'h0, eff[9] | sw});
        chk("freq", {30'h0, o_core_freq_select}, {30'h0, eff[3], eff[11]});
        chk("mhz", {24'h0, o_core_freq_mhz}, {24'h0, mhz[{eff[3], eff[11]}]});
        chk("mode", {30'h0, o_led_display_mode}, {30'h0, eff[7], eff[10]});
    endtask : check_straps

    // ========================================================
    // Main sequence: four fitted patterns, then no resistors
    initial begin
        {i_clock, i_led_link_clock, i_nrst, i_wr, i_rd} = 5'h00;
        i_addr  = 8'h00;
        i_wdata = 32'h0;
        for (int k = 0; k < 5; k++) begin
            strap  = pats[k];
            fitted = (k < 4) ? 12'hFFF : 12'h000;
            eff    = (fitted & strap) | (~fitted & 12'h30A);
            i_nrst <= 1'b0;
            repeat (4) @(posedge i_led_link_clock);
            @(posedge i_clock);
            i_nrst <= 1'b1;
            for (n = 0; n < 20 && o_config_done !== 1'b1; n++) @(posedge i_clock);
            chk("done", {31'h0, o_config_done}, 32'h1);
            if (n == 20) summarize();
            repeat (3) @(posedge i_clock);
            #1 check_straps(1'b0);
            x = {20'h0, eff[7], eff[10], eff[9:8], eff[6:3], eff[11], eff[2:1], 1'b0};
            wr(`STRAP_OFF_STRAPS, 32'hFFFFFFFF);
            rd(`STRAP_OFF_STRAPS, d);
            chk("straps", d, x);
            rd(8'h14, d);
            chk("unmapped", d, 32'h0);
            rd(`STRAP_OFF_STATUS, d);
            chk("status", {31'h0, d[0]}, 32'h1);
            wr(`STRAP_OFF_LED_DIRECT, {22'h0, ~eff[9:0]});
            rd(`STRAP_OFF_LED_DIRECT, d);
            chk("direct", d, {22'h0, ~eff[9:0]});
            chk("pins", {22'h0, o_led_pin_out}, {22'h0, ~eff[9:0]});
            wr(`STRAP_OFF_CTRL, 32'h1);
            repeat (2) @(posedge i_clock);
            // Pads now carry LED data, straps must not follow them
            #1 check_straps(1'b1);
            word = 16'hA5C3 + 16'(k);
            wr(`STRAP_OFF_LED_SERIAL, {16'h0, word});
            for (n = 0; n < 12000 && seen_word !== word; n++) @(posedge i_clock);
            chk("serial", {16'h0, seen_word}, {16'h0, word});
            chk("link_oe", {30'h0, o_led_shift_clock_oe,
                o_led_serial_data_oe}, 32'h3);
            if (n == 12000) summarize();
        end
        summarize();
    end
endmodule : tb_top
